/* File: src/rcdp_pkg.sv */
// package for the read calibration debug port: sizes, bus map, states, carriers
// assumes a single 25 MHz design clock and a classic wishbone register bus
package rcdp_pkg;

  // ---------------------------------------------------------------------------
  // sizes
  // ---------------------------------------------------------------------------
  // one calibration group per i/o bank holding data and strobes
  localparam int unsigned BANK_COUNT  = 4;
  localparam int unsigned GROUP_COUNT = BANK_COUNT;
  localparam int unsigned TAP_W       = 6;
  localparam int unsigned GRP_IDX_W   = $clog2(GROUP_COUNT);
  localparam logic [TAP_W-1:0] TAP_MIN = 6'h00;
  localparam logic [TAP_W-1:0] TAP_MAX = 6'h3F;
  localparam logic [TAP_W-1:0] TAP_ONE = 6'h01;

  // cycles between a strobe tap step and the next look at the filtered strobe;
  // covers the three synchroniser stages plus one
  localparam int unsigned   WAIT_W        = 3;
  localparam logic [WAIT_W-1:0] SETTLE_CYCLES = 3'h4;
  localparam logic [WAIT_W-1:0] WAIT_ZERO     = 3'h0;

  // ---------------------------------------------------------------------------
  // wishbone register map (byte addresses)
  // ---------------------------------------------------------------------------
  localparam int unsigned ADDR_W   = 4;
  localparam int unsigned DATA_W   = 32;
  localparam logic [ADDR_W-1:0] CTRL_ADDR   = 4'h0;
  localparam logic [ADDR_W-1:0] STATUS_ADDR = 4'h4;
  localparam logic [ADDR_W-1:0] GSEL_ADDR   = 4'h8;
  localparam logic [ADDR_W-1:0] TAPS_ADDR   = 4'hC;

  // field positions
  localparam int unsigned CTRL_START_BIT    = 0;
  localparam int unsigned STATUS_BUSY_BIT   = 0;
  localparam int unsigned STATUS_DQS_LSB    = 8;
  localparam int unsigned STATUS_DATA_LSB   = 16;
  localparam int unsigned STATUS_FIRST_LSB  = 24;
  localparam int unsigned TAPS_DQS_LSB      = 0;
  localparam int unsigned TAPS_DATA_LSB     = 8;
  localparam int unsigned TAPS_FIRST_LSB    = 16;
  localparam int unsigned TAPS_SECOND_LSB   = 24;
  localparam logic [DATA_W-1:0] ZERO_WORD   = 32'h0000_0000;

  // ---------------------------------------------------------------------------
  // types
  // ---------------------------------------------------------------------------
  typedef enum logic [2:0] {
    CAL_IDLE, CAL_SEEK_FIRST, CAL_SEEK_SECOND, CAL_CENTER, CAL_DATA, CAL_DONE
  } rcdp_cal_state_t;

  // tap adjust controls from the debug logic, all on the design clock
  typedef struct packed {
    logic up_all;
    logic down_all;
    logic sel_all;
    logic up_grp;
    logic down_grp;
  } rcdp_adjust_t;

  // wishbone request as presented by the master
  typedef struct packed {
    logic              cyc;
    logic              stb;
    logic              we;
    logic [3:0]        sel;
    logic [ADDR_W-1:0] adr;
    logic [DATA_W-1:0] dat;
  } rcdp_wb_req_t;

endpackage

/* File: src/rcdp_debug_port.sv */
// read calibration debug port: strobe edge search, centering, data tap
// placement, debug tap nudging and a wishbone view of the results
// assumes debug controls come from logic on clk_i; strobe samples come from
// the capture flops in another timing domain and are synchronised here
`timescale 1ns/1ps

// Behaviour
// - all read data bits of one group share one delay tap value.
// - group count parameter equals number of banks holding data and strobes.
// - a group is the data bits and strobes sitting in one bank.
// - global increment high raises every data tap one step per clock.
// - global decrement high lowers every data tap one step per clock.
// - select-all 1 adjusts every group, 0 only groups in select vector.
// - select inputs ignored in cycles without group increment or decrement.
// - select vector has one bit per group; a 1 marks that group.
// - group increment high raises selected group taps one step per clock.
// - group decrement high lowers selected group taps one step per clock.
// - per-group flag goes 1 once first strobe edge is detected.
// - per-group 6-bit count of strobe taps stepped before first edge.
// - per-group flag goes 1 once second strobe edge is detected.
// - per-group 6-bit count of strobe taps stepped until second edge.
// - per-group done bit goes 1 when strobe centering is finished.
// - per-group 6-bit applied strobe tap count, never past delay range.
// - per-group 6-bit count of taps to apply to the data bits.
// - per-group done bit goes 1 once data taps moved by that count.
// - per-group bit gives first edge polarity, 1 rising, 0 falling.
// - single output is 1 while dummy-read calibration is running.
module rcdp_debug_port (
  // clock and reset
  input  wire logic                                                clk_i,
  input  wire logic                                                rst_i,
  // wishbone slave
  input  wire rcdp_pkg::rcdp_wb_req_t                              wb_req_i,
  output logic [rcdp_pkg::DATA_W-1:0]                              wb_dat_o,
  output logic                                                     wb_ack_o,
  // strobe level seen by the capture flops, one per group
  input  wire logic [rcdp_pkg::GROUP_COUNT-1:0]                    strobe_level_i,
  // debug tap adjust controls
  input  wire rcdp_pkg::rcdp_adjust_t                              adjust_i,
  input  wire logic [rcdp_pkg::GROUP_COUNT-1:0]                    group_sel_i,
  // tap settings towards the input delay elements
  output logic [rcdp_pkg::GROUP_COUNT-1:0][rcdp_pkg::TAP_W-1:0]    data_tap_o,
  output logic [rcdp_pkg::GROUP_COUNT-1:0][rcdp_pkg::TAP_W-1:0]    strobe_tap_o,
  // calibration status
  output logic [rcdp_pkg::GROUP_COUNT-1:0]                         first_edge_o,
  output logic [rcdp_pkg::GROUP_COUNT-1:0][rcdp_pkg::TAP_W-1:0]    first_edge_taps_o,
  output logic [rcdp_pkg::GROUP_COUNT-1:0]                         second_edge_o,
  output logic [rcdp_pkg::GROUP_COUNT-1:0][rcdp_pkg::TAP_W-1:0]    second_edge_taps_o,
  output logic [rcdp_pkg::GROUP_COUNT-1:0]                         strobe_done_o,
  output logic [rcdp_pkg::GROUP_COUNT-1:0][rcdp_pkg::TAP_W-1:0]    data_tap_count_o,
  output logic [rcdp_pkg::GROUP_COUNT-1:0]                         data_done_o,
  output logic [rcdp_pkg::GROUP_COUNT-1:0]                         first_rising_o,
  output logic                                                     calibrating_o
);

  localparam int unsigned G = rcdp_pkg::GROUP_COUNT;

  // ---------------------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------------------
  // saturating one-step move; both directions at once means hold
  function automatic logic [rcdp_pkg::TAP_W-1:0] step_tap(
    input logic [rcdp_pkg::TAP_W-1:0] tap,
    input logic                       inc,
    input logic                       dec
  );
    logic [rcdp_pkg::TAP_W-1:0] r;
    r = tap;
    if (inc && !dec && tap != rcdp_pkg::TAP_MAX) begin
      r = tap + rcdp_pkg::TAP_ONE;
    end else if (dec && !inc && tap != rcdp_pkg::TAP_MIN) begin
      r = tap - rcdp_pkg::TAP_ONE;
    end
    return r;
  endfunction

  // wishbone decode, used for both write and read
  function automatic logic hit(
    input rcdp_pkg::rcdp_wb_req_t   req,
    input logic [rcdp_pkg::ADDR_W-1:0] addr
  );
    return req.adr == addr;
  endfunction

  // ---------------------------------------------------------------------------
  // state
  // ---------------------------------------------------------------------------
  rcdp_pkg::rcdp_cal_state_t                 st_reg     [G];
  logic [rcdp_pkg::WAIT_W-1:0]               wait_reg   [G];
  logic [G-1:0]                              ref_reg;
  logic [G-1:0]                              sync1_reg;
  logic [G-1:0]                              sync2_reg;
  logic [G-1:0]                              sync3_reg;
  logic [G-1:0]                              filt_reg;
  logic [G-1:0][rcdp_pkg::TAP_W-1:0]         target_reg;
  logic                                      start_reg;
  logic [rcdp_pkg::GRP_IDX_W-1:0]            gsel_reg;
  logic [G-1:0]                              busy_next;
  logic [G-1:0]                              inc_next;
  logic [G-1:0]                              dec_next;

  // ---------------------------------------------------------------------------
  // strobe synchroniser and filter
  // ---------------------------------------------------------------------------
  // stage one feeds only stage two; a change is taken once stages two and
  // three agree, which rejects a single-cycle glitch near the edge
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
      sync3_reg <= '0;
      filt_reg  <= '0;
    end else begin
      sync1_reg <= strobe_level_i;
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
      for (int g = 0; g < G; g++) begin
        if (sync2_reg[g] == sync3_reg[g]) begin
          filt_reg[g] <= sync3_reg[g];
        end
      end
    end
  end

  // ---------------------------------------------------------------------------
  // debug adjust decode
  // ---------------------------------------------------------------------------
  // select inputs only matter when a group step is asked for
  always_comb begin
    for (int g = 0; g < G; g++) begin
      logic pick;
      logic grp_up;
      logic grp_dn;
      pick   = adjust_i.sel_all || group_sel_i[g];
      grp_up = adjust_i.up_grp && !adjust_i.down_grp && pick;
      grp_dn = adjust_i.down_grp && !adjust_i.up_grp && pick;
      inc_next[g] = (adjust_i.up_all && !adjust_i.down_all) || grp_up;
      dec_next[g] = (adjust_i.down_all && !adjust_i.up_all) || grp_dn;
    end
  end

  // ---------------------------------------------------------------------------
  // per-group calibration engine
  // ---------------------------------------------------------------------------
  // strobe taps walk up until two filtered level changes are seen, then back
  // down to the midpoint; no second edge within the range ends the search
  // with the edge flags telling software which step failed
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int g = 0; g < G; g++) begin
        st_reg[g]   <= rcdp_pkg::CAL_IDLE;
        wait_reg[g] <= rcdp_pkg::WAIT_ZERO;
      end
      ref_reg            <= '0;
      strobe_tap_o       <= '0;
      first_edge_o       <= '0;
      second_edge_o      <= '0;
      first_edge_taps_o  <= '0;
      second_edge_taps_o <= '0;
      first_rising_o     <= '0;
      strobe_done_o      <= '0;
      target_reg         <= '0;
    end else begin
      for (int g = 0; g < G; g++) begin
        if (wait_reg[g] != rcdp_pkg::WAIT_ZERO) begin
          wait_reg[g] <= wait_reg[g] - 3'h1;
        end
        unique case (st_reg[g])
          rcdp_pkg::CAL_IDLE, rcdp_pkg::CAL_DONE: begin
            if (start_reg) begin
              st_reg[g]             <= rcdp_pkg::CAL_SEEK_FIRST;
              strobe_tap_o[g]       <= rcdp_pkg::TAP_MIN;
              first_edge_o[g]       <= 1'b0;
              second_edge_o[g]      <= 1'b0;
              first_edge_taps_o[g]  <= rcdp_pkg::TAP_MIN;
              second_edge_taps_o[g] <= rcdp_pkg::TAP_MIN;
              first_rising_o[g]     <= 1'b0;
              strobe_done_o[g]      <= 1'b0;
              wait_reg[g]           <= rcdp_pkg::SETTLE_CYCLES;
              ref_reg[g]            <= filt_reg[g];
            end
          end
          rcdp_pkg::CAL_SEEK_FIRST: begin
            if (wait_reg[g] == rcdp_pkg::WAIT_ZERO) begin
              if (filt_reg[g] != ref_reg[g]) begin
                first_edge_o[g]      <= 1'b1;
                first_edge_taps_o[g] <= strobe_tap_o[g];
                first_rising_o[g]    <= filt_reg[g];
                ref_reg[g]           <= filt_reg[g];
                st_reg[g]            <= rcdp_pkg::CAL_SEEK_SECOND;
              end else if (strobe_tap_o[g] == rcdp_pkg::TAP_MAX) begin
                st_reg[g] <= rcdp_pkg::CAL_DONE; // range exhausted
              end else begin
                strobe_tap_o[g] <= step_tap(strobe_tap_o[g], 1'b1, 1'b0);
                wait_reg[g]     <= rcdp_pkg::SETTLE_CYCLES;
              end
            end
          end
          rcdp_pkg::CAL_SEEK_SECOND: begin
            if (wait_reg[g] == rcdp_pkg::WAIT_ZERO) begin
              if (filt_reg[g] != ref_reg[g]) begin
                second_edge_o[g]      <= 1'b1;
                second_edge_taps_o[g] <= strobe_tap_o[g];
                // midpoint of the two edges, no overflow since tap_half sums them in 7 bits
                target_reg[g] <= tap_half(first_edge_taps_o[g], strobe_tap_o[g]);
                st_reg[g]     <= rcdp_pkg::CAL_CENTER;
              end else if (strobe_tap_o[g] == rcdp_pkg::TAP_MAX) begin
                st_reg[g] <= rcdp_pkg::CAL_DONE;
              end else begin
                strobe_tap_o[g] <= step_tap(strobe_tap_o[g], 1'b1, 1'b0);
                wait_reg[g]     <= rcdp_pkg::SETTLE_CYCLES;
              end
            end
          end
          rcdp_pkg::CAL_CENTER: begin
            // one tap per cycle back towards the midpoint
            if (strobe_tap_o[g] == target_reg[g]) begin
              strobe_done_o[g] <= 1'b1;
              st_reg[g]        <= rcdp_pkg::CAL_DATA;
            end else begin
              strobe_tap_o[g] <= step_tap(strobe_tap_o[g], 1'b0, 1'b1);
            end
          end
          rcdp_pkg::CAL_DATA: begin
            if (data_done_o[g]) begin
              st_reg[g] <= rcdp_pkg::CAL_DONE;
            end
          end
          default: begin
            st_reg[g] <= rcdp_pkg::CAL_IDLE;
          end
        endcase
      end
    end
  end

  // midpoint of two tap values
  function automatic logic [rcdp_pkg::TAP_W-1:0] tap_half(
    input logic [rcdp_pkg::TAP_W-1:0] a,
    input logic [rcdp_pkg::TAP_W-1:0] b
  );
    logic [rcdp_pkg::TAP_W:0] s;
    s = {1'b0, a} + {1'b0, b};
    return s[rcdp_pkg::TAP_W:1];
  endfunction

  // ---------------------------------------------------------------------------
  // data tap per group
  // ---------------------------------------------------------------------------
  // one tap value per group drives every data bit in that bank; placement
  // owns the tap while it runs, so debug nudges are ignored until it is done
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      data_tap_o       <= '0;
      data_tap_count_o <= '0;
      data_done_o      <= '0;
    end else begin
      for (int g = 0; g < G; g++) begin
        if (start_reg && (st_reg[g] == rcdp_pkg::CAL_IDLE ||
                          st_reg[g] == rcdp_pkg::CAL_DONE)) begin
          data_tap_o[g]       <= rcdp_pkg::TAP_MIN;
          data_tap_count_o[g] <= rcdp_pkg::TAP_MIN;
          data_done_o[g]      <= 1'b0;
        end else if (st_reg[g] == rcdp_pkg::CAL_CENTER &&
                     strobe_tap_o[g] == target_reg[g]) begin
          data_tap_count_o[g] <= target_reg[g];
        end else if (st_reg[g] == rcdp_pkg::CAL_DATA && !data_done_o[g]) begin
          if (data_tap_o[g] == data_tap_count_o[g]) begin
            data_done_o[g] <= 1'b1;
          end else begin
            data_tap_o[g] <= step_tap(data_tap_o[g], 1'b1, 1'b0);
          end
        end else begin
          data_tap_o[g] <= step_tap(data_tap_o[g], inc_next[g], dec_next[g]);
        end
      end
    end
  end

  // ---------------------------------------------------------------------------
  // calibration in progress
  // ---------------------------------------------------------------------------
  always_comb begin
    for (int g = 0; g < G; g++) begin
      busy_next[g] = st_reg[g] != rcdp_pkg::CAL_IDLE && st_reg[g] != rcdp_pkg::CAL_DONE;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      calibrating_o <= 1'b0;
    end else begin
      calibrating_o <= |busy_next || start_reg;
    end
  end

  // ---------------------------------------------------------------------------
  // wishbone slave
  // ---------------------------------------------------------------------------
  // ack one cycle after the request and dropped the cycle after; the write
  // takes effect on the edge that raises ack, one edge before the master samples it
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= wb_req_i.cyc && wb_req_i.stb && !wb_ack_o;
    end
  end

  // start is a one-cycle pulse; rewriting while busy is ignored per group
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      start_reg <= 1'b0;
      gsel_reg  <= '0;
    end else begin
      start_reg <= 1'b0;
      if (wb_req_i.cyc && wb_req_i.stb && wb_req_i.we && !wb_ack_o && wb_req_i.sel[0]) begin
        if (hit(wb_req_i, rcdp_pkg::CTRL_ADDR)) begin
          start_reg <= wb_req_i.dat[rcdp_pkg::CTRL_START_BIT];
        end
        if (hit(wb_req_i, rcdp_pkg::GSEL_ADDR)) begin
          gsel_reg <= wb_req_i.dat[rcdp_pkg::GRP_IDX_W-1:0];
        end
      end
    end
  end

  // read data registered with the ack; unmapped addresses read zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= rcdp_pkg::ZERO_WORD;
    end else begin
      wb_dat_o <= rcdp_pkg::ZERO_WORD;
      if (wb_req_i.cyc && wb_req_i.stb && !wb_req_i.we && !wb_ack_o) begin
        if (hit(wb_req_i, rcdp_pkg::CTRL_ADDR)) begin
          wb_dat_o[rcdp_pkg::CTRL_START_BIT] <= start_reg;
        end else if (hit(wb_req_i, rcdp_pkg::STATUS_ADDR)) begin
          wb_dat_o[rcdp_pkg::STATUS_BUSY_BIT]                 <= calibrating_o;
          wb_dat_o[rcdp_pkg::STATUS_DQS_LSB +: G]             <= strobe_done_o;
          wb_dat_o[rcdp_pkg::STATUS_DATA_LSB +: G]            <= data_done_o;
          wb_dat_o[rcdp_pkg::STATUS_FIRST_LSB +: G]           <= first_rising_o;
        end else if (hit(wb_req_i, rcdp_pkg::GSEL_ADDR)) begin
          wb_dat_o[rcdp_pkg::GRP_IDX_W-1:0] <= gsel_reg;
        end else if (hit(wb_req_i, rcdp_pkg::TAPS_ADDR)) begin
          wb_dat_o[rcdp_pkg::TAPS_DQS_LSB +: rcdp_pkg::TAP_W]    <= strobe_tap_o[gsel_reg];
          wb_dat_o[rcdp_pkg::TAPS_DATA_LSB +: rcdp_pkg::TAP_W]   <= data_tap_o[gsel_reg];
          wb_dat_o[rcdp_pkg::TAPS_FIRST_LSB +: rcdp_pkg::TAP_W]  <= first_edge_taps_o[gsel_reg];
          wb_dat_o[rcdp_pkg::TAPS_SECOND_LSB +: rcdp_pkg::TAP_W] <= second_edge_taps_o[gsel_reg];
        end
      end
    end
  end

endmodule

/* File: tb/rcdp_debug_port_properties.sv */
// checker for the read calibration debug port: bus answer, tap nudging, flags
// assumes it is bound to rcdp_debug_port and sees only that module's ports
`timescale 1ns/1ps
module rcdp_debug_port_properties (
  // clock and reset
  input wire logic                                             clk_i,
  input wire logic                                             rst_i,
  // inputs of the port
  input wire rcdp_pkg::rcdp_wb_req_t                           wb_req_i,
  input wire rcdp_pkg::rcdp_adjust_t                           adjust_i,
  input wire logic [rcdp_pkg::GROUP_COUNT-1:0]                 group_sel_i,
  // outputs of the port
  input wire logic                                             wb_ack_o,
  input wire logic [rcdp_pkg::GROUP_COUNT-1:0][rcdp_pkg::TAP_W-1:0] data_tap_o,
  input wire logic [rcdp_pkg::GROUP_COUNT-1:0]                 first_edge_o,
  input wire logic [rcdp_pkg::GROUP_COUNT-1:0]                 second_edge_o,
  input wire logic                                             calibrating_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // -------------------------------------------------------------------------
  // sequences
  // -------------------------------------------------------------------------
  // no engine and no bus traffic, so only the debug controls may move taps
  sequence s_quiet;
    !calibrating_o && !wb_req_i.cyc;
  endsequence
  sequence s_start;
    wb_req_i.cyc && wb_req_i.stb && wb_req_i.we && wb_req_i.sel[0] && !wb_ack_o
      && wb_req_i.adr == rcdp_pkg::CTRL_ADDR && wb_req_i.dat[0] && !calibrating_o;
  endsequence
  // -------------------------------------------------------------------------
  // properties
  // -------------------------------------------------------------------------
  property p_ack_resp;
    wb_req_i.cyc && wb_req_i.stb && !wb_ack_o |=> wb_ack_o;
  endproperty
  property p_ack_pulse;
    wb_ack_o |=> !wb_ack_o;
  endproperty
  property p_all_up;
    s_quiet ##0 (adjust_i == 5'h10 && data_tap_o[0] != 6'h3F)
      |=> data_tap_o[0] == $past(data_tap_o[0]) + 6'h01;
  endproperty
  property p_all_down;
    s_quiet ##0 (adjust_i == 5'h08 && data_tap_o[1] != 6'h00)
      |=> data_tap_o[1] == $past(data_tap_o[1]) - 6'h01;
  endproperty
  property p_grp_up;
    s_quiet ##0 (adjust_i == 5'h02 && group_sel_i[2] && data_tap_o[2] != 6'h3F)
      |=> data_tap_o[2] == $past(data_tap_o[2]) + 6'h01;
  endproperty
  property p_unsel;
    s_quiet ##0 (!adjust_i.up_all && !adjust_i.down_all && !adjust_i.sel_all
      && !group_sel_i[3]) |=> $stable(data_tap_o[3]);
  endproperty
  property p_both;
    s_quiet ##0 (adjust_i == 5'h18) |=> $stable(data_tap_o);
  endproperty
  property p_edge_order;
    second_edge_o[0] |-> first_edge_o[0];
  endproperty
  property p_start;
    s_start |-> ##[1:3] calibrating_o;
  endproperty
  a_ack_resp: assert property (p_ack_resp) else $error("no ack after request");
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack held too long");
  a_all_up: assert property (p_all_up) else $error("global up missed");
  a_all_down: assert property (p_all_down) else $error("global down missed");
  a_grp_up: assert property (p_grp_up) else $error("group up missed");
  a_unsel: assert property (p_unsel) else $error("unselected tap moved");
  a_both: assert property (p_both) else $error("up and down moved a tap");
  a_edge_order: assert property (p_edge_order) else $error("second before first");
  a_start: assert property (p_start) else $error("start not shown");
endmodule

bind rcdp_debug_port rcdp_debug_port_properties u_rcdp_debug_port_properties (
  .clk_i, .rst_i, .wb_req_i, .adjust_i, .group_sel_i, .wb_ack_o, .data_tap_o,
  .first_edge_o, .second_edge_o, .calibrating_o);

/* File: tb/rcdp_strobe_model.sv */
// strobe model: level seen per group as a function of its strobe tap
// assumes the port's strobe taps; one group sees a falling first edge
`timescale 1ns/1ps
module rcdp_strobe_model #(
  parameter int unsigned FIRST_BASE = 5,
  parameter int unsigned SPAN_BASE  = 10,
  parameter int unsigned FALL_GROUP = 3
) (
  // tap in, level out
  input  wire logic [rcdp_pkg::GROUP_COUNT-1:0][rcdp_pkg::TAP_W-1:0] strobe_tap_i,
  output logic [rcdp_pkg::GROUP_COUNT-1:0]                       strobe_level_o
);
  // high window from first to second edge tap, inverted for the falling group
  always_comb begin
    for (int g = 0; g < rcdp_pkg::GROUP_COUNT; g++) begin
      strobe_level_o[g] = (strobe_tap_i[g] >= FIRST_BASE + 3 * g
        && strobe_tap_i[g] < FIRST_BASE + 4 * g + SPAN_BASE) ^ (g == FALL_GROUP);
    end
  end
endmodule

/* File: tb/test_rcdp_debug_port.sv */
// testbench for the read calibration debug port: nudging, calibration, bus
// assumes the strobe model as far side and a 25 MHz clock
`timescale 1ns/1ps
module test_rcdp_debug_port;
  typedef logic [rcdp_pkg::GROUP_COUNT-1:0][rcdp_pkg::TAP_W-1:0] rcdp_tvec_t;
  typedef logic [rcdp_pkg::GROUP_COUNT-1:0]                      rcdp_gvec_t;
  logic clk_i;
  logic rst_i;
  rcdp_pkg::rcdp_wb_req_t wb_req_i;
  rcdp_pkg::rcdp_adjust_t adjust_i;
  logic [31:0]            wb_dat_o;
  logic                   wb_ack_o;
  logic                   calibrating_o;
  rcdp_gvec_t             lvl, group_sel_i, fe, se, sd, dd, fr;
  rcdp_tvec_t             dtap, stap, fet, set, dcnt, exp_t, ef, es, em;
  logic [31:0]            q;
  int                     err_total, samples_checked, n;
  // -------------------------------------------------------------------------
  // clock, design and far side
  // -------------------------------------------------------------------------
  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end
  rcdp_debug_port u_rcdp_debug_port (.clk_i, .rst_i, .wb_req_i, .wb_dat_o, .wb_ack_o,
    .strobe_level_i(lvl), .adjust_i, .group_sel_i, .data_tap_o(dtap), .strobe_tap_o(stap),
    .first_edge_o(fe), .first_edge_taps_o(fet), .second_edge_o(se),
    .second_edge_taps_o(set), .strobe_done_o(sd), .data_tap_count_o(dcnt),
    .data_done_o(dd), .first_rising_o(fr), .calibrating_o);
  rcdp_strobe_model u_rcdp_strobe_model (.strobe_tap_i(stap), .strobe_level_o(lvl));
  // -------------------------------------------------------------------------
  // compares, bus and stepping
  // -------------------------------------------------------------------------
  task automatic chk_w(input string nm, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chk_t(input string nm, input rcdp_tvec_t e, input rcdp_tvec_t g);
    chk_w(nm, {8'h00, e}, {8'h00, g});
  endtask
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // classic single cycle; holds everything until ack is sampled high
  task automatic wb(input logic we, input logic [3:0] a, input logic [31:0] d);
    wb_req_i <= '{cyc: 1'b1, stb: 1'b1, we: we, sel: 4'hF, adr: a, dat: d};
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 50);
    if (n >= 50) begin
      err_total++;
      complete_run();
    end
    q = wb_dat_o;
    wb_req_i <= '0;
    @(posedge clk_i);
  endtask
  // expected tap after one cycle of the given controls
  function automatic logic [5:0] nxt(input logic [5:0] t, input logic [4:0] a, input logic s);
    logic up;
    logic dn;
    up = (a[4] & !a[3]) | (a[1] & !a[0] & (a[2] | s));
    dn = (a[3] & !a[4]) | (a[0] & !a[1] & (a[2] | s));
    if (up && !dn && t != 6'h3F) return t + 6'h01;
    if (dn && !up && t != 6'h00) return t - 6'h01;
    return t;
  endfunction
  // drive on the edge, compare what the previous cycle's controls produced
  task automatic step(input logic [4:0] a, input rcdp_gvec_t s);
    adjust_i <= a;
    group_sel_i <= s;
    @(posedge clk_i);
    chk_t("data_tap_o", exp_t, dtap);
    for (int g = 0; g < 4; g++) exp_t[g] = nxt(exp_t[g], a, s[g]);
  endtask
  // -------------------------------------------------------------------------
  // main sequence
  // -------------------------------------------------------------------------
  initial begin
    {rst_i, wb_req_i, adjust_i, group_sel_i, exp_t} = '1;
    {wb_req_i, adjust_i, group_sel_i, exp_t} = '0;
    void'($urandom(63));
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    chk_w("group_count", rcdp_pkg::BANK_COUNT, rcdp_pkg::GROUP_COUNT);
    wb(1'b0, rcdp_pkg::STATUS_ADDR, 32'h0);
    chk_w("status", 32'h0, q);
    wb(1'b0, 4'h2, 32'h0);
    chk_w("unmapped", 32'h0, q);
    $display("reset test done");
    // saturate at both ends, then a mixed sweep and random controls
    repeat (66) step(5'h10, 4'h0);
    step(5'h18, 4'hF);
    repeat (66) step(5'h08, 4'h0);
    repeat (3) step(5'h02, 4'h5);
    repeat (2) step(5'h06, 4'h0);
    step(5'h01, 4'h1);
    repeat (300) step(5'($urandom), 4'($urandom));
    step(5'h00, 4'h0);
    step(5'h00, 4'h0);
    $display("adjust test done");
    // calibration against the strobe model
    wb(1'b1, rcdp_pkg::CTRL_ADDR, 32'h1);
    wb(1'b0, rcdp_pkg::STATUS_ADDR, 32'h0);
    chk_w("busy", 32'h1, q & 32'h1);
    n = 0;
    while (calibrating_o !== 1'b0 && n < 3000) begin
      @(posedge clk_i);
      n++;
    end
    if (n >= 3000) begin
      err_total++;
      complete_run();
    end
    for (int g = 0; g < 4; g++) begin
      ef[g] = 6'(5 + 3 * g);
      es[g] = 6'(15 + 4 * g);
      em[g] = 6'((ef[g] + es[g]) >> 1);
    end
    chk_w("flags", 32'hFFFF_0007,
      {fe, se, sd, dd, 12'h000, fr});
    chk_t("first_taps", ef, fet);
    chk_t("second_taps", es, set);
    chk_t("strobe_tap", em, stap);
    chk_t("data_count", em, dcnt);
    chk_t("data_tap", em, dtap);
    wb(1'b0, rcdp_pkg::STATUS_ADDR, 32'h0);
    chk_w("status", 32'h070F_0F00, q);
    wb(1'b1, rcdp_pkg::GSEL_ADDR, 32'h1);
    wb(1'b0, rcdp_pkg::TAPS_ADDR, 32'h0);
    chk_w("taps", {2'b0, es[1], 2'b0, ef[1], 2'b0, em[1], 2'b0, em[1]}, q);
    $display("calibration test done");
    complete_run();
  end
endmodule
